// [core/sfm_pkg.sv]
package sfm_pkg;

    // buffer geometry
    localparam int FIFO_DEPTH = 32;
    localparam int PTR_W = 5;
    localparam int LVL_W = 6;
    localparam int SAMPLE_W = 40;

    // register offsets (7-bit sub-address space)
    localparam logic [6:0] ADDR_TRIG_CFG = 7'h0b;
    localparam logic [6:0] ADDR_CTRL_TWO = 7'h11;
    localparam logic [6:0] ADDR_CTRL_THREE = 7'h12;
    localparam logic [6:0] ADDR_BUF_CFG = 7'h14;
    localparam logic [6:0] ADDR_BUF_STATE = 7'h26;
    localparam logic [6:0] ADDR_PRESS_XL = 7'h28;
    localparam logic [6:0] ADDR_PRESS_M = 7'h29;
    localparam logic [6:0] ADDR_PRESS_H = 7'h2a;
    localparam logic [6:0] ADDR_TEMP_L = 7'h2b;
    localparam logic [6:0] ADDR_TEMP_H = 7'h2c;

    // control_two fields
    localparam int CT2_BUF_EN_BIT = 6;
    localparam int CT2_WTM_STOP_BIT = 5;
    localparam int CT2_AUTO_INC_BIT = 4;
    localparam logic [7:0] CTRL_TWO_RST = 8'h10;

    // control_three routing bits onto the sample-ready pin
    localparam int CT3_WTM_IRQ_BIT = 0;
    localparam int CT3_OVR_IRQ_BIT = 1;
    localparam int CT3_FULL_IRQ_BIT = 2;
    localparam logic [7:0] CTRL_THREE_RST = 8'h00;

    // buffer_config fields
    localparam int BCFG_MODE_LSB = 5;
    localparam int BCFG_WTM_LSB = 0;
    localparam logic [7:0] BUF_CFG_RST = 8'h00;
    localparam logic [7:0] TRIG_CFG_RST = 8'h00;

    // buffer_state fields
    localparam int BST_WTM_BIT = 7;
    localparam int BST_OVR_BIT = 6;

    // mode field encodings
    localparam logic [2:0] MODE_BYPASS = 3'h0;
    localparam logic [2:0] MODE_FIFO = 3'h1;
    localparam logic [2:0] MODE_STREAM = 3'h2;
    localparam logic [2:0] MODE_STREAM_FIFO = 3'h3;
    localparam logic [2:0] MODE_BYPASS_STREAM = 3'h4;
    localparam logic [2:0] MODE_BYPASS_FIFO = 3'h7;

    // behaviour the buffer is following at a given moment
    typedef enum logic [1:0] {
        SFM_BEH_BYPASS,
        SFM_BEH_FIFO,
        SFM_BEH_STREAM
    } sfm_beh_t;

    // one combined sample from the measurement chain
    typedef struct packed {
        logic [15:0] temp;
        logic [23:0] press;
    } sfm_sample_t;

    // byte-wide register port request
    typedef struct packed {
        logic addr_load;
        logic [6:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfm_req_t;

endpackage

// [core/sfm_store.sv]
`timescale 1ns/1ps

// sample storage, flip-flops addressed by index, read is combinational
module sfm_store #(
    parameter int WIDTH = sfm_pkg::SAMPLE_W,
    parameter int DEPTH = sfm_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [sfm_pkg::PTR_W-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [sfm_pkg::PTR_W-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
    } sfm_mem_t;

    sfm_mem_t mem_r;
    sfm_mem_t mem_nxt;

    initial begin
        if (DEPTH < 2 || DEPTH > (1 << sfm_pkg::PTR_W)) begin
            $error("sfm_store: depth out of range");
        end
    end

    // one slot written per cycle at most
    always_comb begin
        mem_nxt = mem_r;
        if (wr_en) begin
            mem_nxt.mem[wr_idx] = wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_r <= '0;
        end else begin
            mem_r <= mem_nxt;
        end
    end

    assign rd_data = mem_r.mem[rd_idx];

endmodule

// [core/sfm_top.sv]
`timescale 1ns/1ps

module sfm_top #(
    parameter int DEPTH = sfm_pkg::FIFO_DEPTH
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SAMPLE_VALID,
    input wire sfm_pkg::sfm_sample_t SAMPLE_DATA,
    input wire logic TRIGGER,
    input wire sfm_pkg::sfm_req_t REG_REQ,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    output logic [7:0] TRIG_CFG,
    output logic SAMPLE_READY_IRQ_PIN
);

    // whole state of the block except the sample storage and the reset synchronizer
    typedef struct packed {
        logic [7:0] trig_cfg;
        logic [7:0] ctrl_two;
        logic [7:0] ctrl_three;
        logic [7:0] buf_cfg;
        logic [sfm_pkg::PTR_W-1:0] wr_ptr;
        logic [sfm_pkg::PTR_W-1:0] rd_ptr;
        logic [sfm_pkg::LVL_W-1:0] level;
        logic overrun;
        logic trig_seen;
        logic [6:0] sub;
        sfm_pkg::sfm_sample_t latest;
        logic [7:0] rdata;
        logic rvalid;
        logic irq;
    } sfm_state_t;

    localparam logic [sfm_pkg::LVL_W-1:0] DEPTH_LVL = sfm_pkg::LVL_W'(DEPTH);
    localparam logic [sfm_pkg::PTR_W-1:0] PTR_MAX = sfm_pkg::PTR_W'(DEPTH - 1);
    // unit steps at the exact width of the counters they move
    localparam logic [sfm_pkg::PTR_W-1:0] PTR_ONE = {{(sfm_pkg::PTR_W-1){1'b0}}, 1'b1};
    localparam logic [sfm_pkg::LVL_W-1:0] LVL_ONE = {{(sfm_pkg::LVL_W-1){1'b0}}, 1'b1};

    initial begin
        if (DEPTH < 2 || DEPTH > (1 << sfm_pkg::PTR_W) || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("sfm_top: depth must be a power of two from 2 to 32");
        end
    end

    sfm_state_t q_r;
    sfm_state_t q_nxt;
    logic rst_meta_r;
    logic rst_sync_r;
    logic mem_wr_en;
    logic [sfm_pkg::PTR_W-1:0] mem_wr_idx;
    sfm_pkg::sfm_sample_t head;

    // reset release through two flops so the state and storage flops leave reset on the same edge
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // pointer step with wrap at the configured depth
    function automatic logic [sfm_pkg::PTR_W-1:0] ptr_inc(
        input logic [sfm_pkg::PTR_W-1:0] p
    );
        ptr_inc = (p == PTR_MAX) ? '0 : p + PTR_ONE;
    endfunction

    // behaviour followed for the current mode and trigger history
    function automatic sfm_pkg::sfm_beh_t beh_of(
        input logic [2:0] mode,
        input logic trig
    );
        case (mode)
            sfm_pkg::MODE_FIFO: beh_of = sfm_pkg::SFM_BEH_FIFO;
            sfm_pkg::MODE_STREAM: beh_of = sfm_pkg::SFM_BEH_STREAM;
            sfm_pkg::MODE_STREAM_FIFO: begin
                beh_of = trig ? sfm_pkg::SFM_BEH_FIFO : sfm_pkg::SFM_BEH_STREAM;
            end
            sfm_pkg::MODE_BYPASS_STREAM: begin
                beh_of = trig ? sfm_pkg::SFM_BEH_STREAM : sfm_pkg::SFM_BEH_BYPASS;
            end
            sfm_pkg::MODE_BYPASS_FIFO: begin
                beh_of = trig ? sfm_pkg::SFM_BEH_FIFO : sfm_pkg::SFM_BEH_BYPASS;
            end
            // 000 and the two unused codes keep the buffer idle
            default: beh_of = sfm_pkg::SFM_BEH_BYPASS;
        endcase
    endfunction

    sfm_store #(
        .WIDTH(sfm_pkg::SAMPLE_W),
        .DEPTH(DEPTH)
    ) u_store (
        .clk(CLK),
        .rst_n(rst_sync_r),
        .wr_en(mem_wr_en),
        .wr_idx(mem_wr_idx),
        .wr_data(SAMPLE_DATA),
        .rd_idx(q_r.rd_ptr),
        .rd_data(head)
    );

    // next-state logic: register port first, then buffer movement, then flags
    always_comb begin
        logic buf_en;
        logic wtm_stop;
        logic [2:0] mode;
        logic [4:0] wtm;
        sfm_pkg::sfm_beh_t beh;
        logic pop;
        logic wtm_hit;
        sfm_pkg::sfm_sample_t src;

        q_nxt = q_r;
        buf_en = q_r.ctrl_two[sfm_pkg::CT2_BUF_EN_BIT];
        wtm_stop = q_r.ctrl_two[sfm_pkg::CT2_WTM_STOP_BIT];
        mode = q_r.buf_cfg[sfm_pkg::BCFG_MODE_LSB +: 3];
        wtm = q_r.buf_cfg[sfm_pkg::BCFG_WTM_LSB +: 5];
        beh = beh_of(mode, q_r.trig_seen);
        pop = 1'b0;
        wtm_hit = 1'b0;
        mem_wr_en = 1'b0;
        mem_wr_idx = q_r.wr_ptr;
        q_nxt.rvalid = 1'b0;

        // output bytes come from the oldest entry while the buffer holds data
        src = (buf_en && q_r.level != '0) ? head : q_r.latest;

        // register reads answer one cycle after the strobe
        if (REG_REQ.rd) begin
            q_nxt.rvalid = 1'b1;
            case (q_r.sub)
                sfm_pkg::ADDR_TRIG_CFG: q_nxt.rdata = q_r.trig_cfg;
                sfm_pkg::ADDR_CTRL_TWO: q_nxt.rdata = q_r.ctrl_two;
                sfm_pkg::ADDR_CTRL_THREE: q_nxt.rdata = q_r.ctrl_three;
                sfm_pkg::ADDR_BUF_CFG: q_nxt.rdata = q_r.buf_cfg;
                sfm_pkg::ADDR_BUF_STATE: begin
                    q_nxt.rdata = {wtm_stop && ({1'b0, wtm} <= q_r.level),
                                   q_r.overrun, q_r.level};
                    q_nxt.overrun = 1'b0;
                end
                sfm_pkg::ADDR_PRESS_XL: q_nxt.rdata = src.press[7:0];
                sfm_pkg::ADDR_PRESS_M: q_nxt.rdata = src.press[15:8];
                sfm_pkg::ADDR_PRESS_H: q_nxt.rdata = src.press[23:16];
                sfm_pkg::ADDR_TEMP_L: q_nxt.rdata = src.temp[7:0];
                sfm_pkg::ADDR_TEMP_H: begin
                    q_nxt.rdata = src.temp[15:8];
                    // last byte of an entry retires it, exposing the next oldest
                    pop = buf_en && q_r.level != '0;
                end
                default: q_nxt.rdata = 8'h00;
            endcase
        end

        // register writes; read-only offsets ignore them
        if (REG_REQ.wr) begin
            case (q_r.sub)
                sfm_pkg::ADDR_TRIG_CFG: q_nxt.trig_cfg = REG_REQ.wdata;
                sfm_pkg::ADDR_CTRL_TWO: q_nxt.ctrl_two = REG_REQ.wdata;
                sfm_pkg::ADDR_CTRL_THREE: q_nxt.ctrl_three = REG_REQ.wdata;
                sfm_pkg::ADDR_BUF_CFG: begin
                    q_nxt.buf_cfg = REG_REQ.wdata;
                    // a new mode starts again from the pre-trigger behaviour
                    q_nxt.trig_seen = 1'b0;
                end
                default: q_nxt.trig_seen = q_nxt.trig_seen;
            endcase
        end

        // sub-address: load, then step after each byte while auto-increment is set; output block wraps while the buffer is enabled
        if (REG_REQ.addr_load) begin
            q_nxt.sub = REG_REQ.addr;
        end else if ((REG_REQ.rd || REG_REQ.wr) && q_r.ctrl_two[sfm_pkg::CT2_AUTO_INC_BIT]) begin
            if (buf_en && q_r.sub == sfm_pkg::ADDR_TEMP_H) begin
                q_nxt.sub = sfm_pkg::ADDR_PRESS_XL;
            end else begin
                q_nxt.sub = q_r.sub + 7'h01;
            end
        end

        // retire the entry just read out
        if (pop) begin
            q_nxt.rd_ptr = ptr_inc(q_r.rd_ptr);
            q_nxt.level = q_r.level - LVL_ONE;
        end

        // the plain output registers always follow the newest sample
        if (SAMPLE_VALID) begin
            q_nxt.latest = SAMPLE_DATA;
        end

        // buffer movement
        if (!buf_en || beh == sfm_pkg::SFM_BEH_BYPASS) begin
            // inactive buffer holds nothing; pointers restart at zero
            q_nxt.level = '0;
            q_nxt.wr_ptr = '0;
            q_nxt.rd_ptr = '0;
        end else if (SAMPLE_VALID) begin
            if (q_nxt.level == DEPTH_LVL) begin
                // full after any read in the same cycle: sample is an overrun
                q_nxt.overrun = 1'b1;
                if (beh == sfm_pkg::SFM_BEH_STREAM) begin
                    // oldest slot is the write slot; both pointers move together
                    mem_wr_en = 1'b1;
                    q_nxt.wr_ptr = ptr_inc(q_r.wr_ptr);
                    q_nxt.rd_ptr = ptr_inc(q_nxt.rd_ptr);
                end
                // fill-and-stop drops the sample and keeps the stored ones
            end else begin
                mem_wr_en = 1'b1;
                q_nxt.wr_ptr = ptr_inc(q_r.wr_ptr);
                q_nxt.level = q_nxt.level + LVL_ONE;
            end
        end

        // trigger only matters in the switched modes; set beats a mode write
        if (TRIGGER && buf_en) begin
            q_nxt.trig_seen = 1'b1;
        end

        // an overrun in the same cycle as a status read stays set
        if (SAMPLE_VALID && buf_en && beh != sfm_pkg::SFM_BEH_BYPASS
                && q_nxt.level == DEPTH_LVL && q_r.level == DEPTH_LVL && !pop) begin
            q_nxt.overrun = 1'b1;
        end

        // watermark flag, from the level that will be registered
        wtm_hit = wtm_stop && ({1'b0, wtm} <= q_nxt.level);

        // pin is a registered OR of the routed status events
        q_nxt.irq = (q_r.ctrl_three[sfm_pkg::CT3_WTM_IRQ_BIT] && wtm_hit)
                  || (q_r.ctrl_three[sfm_pkg::CT3_OVR_IRQ_BIT] && q_nxt.overrun)
                  || (q_r.ctrl_three[sfm_pkg::CT3_FULL_IRQ_BIT]
                      && q_nxt.level == DEPTH_LVL);
    end

    // state register; reset values come from the package
    always_ff @(posedge CLK or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            q_r <= '0;
            q_r.ctrl_two <= sfm_pkg::CTRL_TWO_RST;
            q_r.ctrl_three <= sfm_pkg::CTRL_THREE_RST;
            q_r.buf_cfg <= sfm_pkg::BUF_CFG_RST;
            q_r.trig_cfg <= sfm_pkg::TRIG_CFG_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    // outputs straight from state flops
    assign REG_RDATA = q_r.rdata;
    assign REG_RVALID = q_r.rvalid;
    assign TRIG_CFG = q_r.trig_cfg;
    assign SAMPLE_READY_IRQ_PIN = q_r.irq;

endmodule

// [test/sample_fifo_modes_tb_top.sv]
`timescale 1ns/1ps

module sample_fifo_modes_tb_top;
    logic CLK;
    logic RST_N;
    logic SAMPLE_VALID;
    sfm_pkg::sfm_sample_t SAMPLE_DATA;
    logic TRIGGER;
    sfm_pkg::sfm_req_t REG_REQ;
    logic [7:0] REG_RDATA;
    logic REG_RVALID;
    logic [7:0] TRIG_CFG;
    logic SAMPLE_READY_IRQ_PIN;
    logic [7:0] q[$];
    logic [7:0] kk;
    logic [7:0] b;
    logic [6:0] ra[5] = '{7'h0b, 7'h11, 7'h12, 7'h14, 7'h26};
    logic [7:0] rv[5] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;

    sfm_top DUT (.CLK(CLK), .RST_N(RST_N), .SAMPLE_VALID(SAMPLE_VALID),
        .SAMPLE_DATA(SAMPLE_DATA), .TRIGGER(TRIGGER), .REG_REQ(REG_REQ),
        .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .TRIG_CFG(TRIG_CFG),
        .SAMPLE_READY_IRQ_PIN(SAMPLE_READY_IRQ_PIN));
    sfm_host host (.clk(CLK), .rdata(REG_RDATA), .rvalid(REG_RVALID), .req(REG_REQ));

    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // the whole run needs a few hundred cycles; this bounds a hang
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    function automatic sfm_pkg::sfm_sample_t mk(input logic [7:0] k);
        return '{temp: {8'hc3, k}, press: {8'h5a, ~k, k}};
    endfunction

    function automatic logic [7:0] sb(input logic [7:0] k, input int j);
        logic [39:0] s;
        s = mk(k);
        return s[8 * j +: 8];
    endfunction

    // one sample per cycle, numbered on from the last one sent
    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge CLK);
            SAMPLE_VALID <= 1'b1;
            SAMPLE_DATA <= mk(kk);
            kk = kk + 8'h01;
        end
        @(posedge CLK);
        SAMPLE_VALID <= 1'b0;
    endtask

    task automatic st(input logic [7:0] e);
        host.rreg(7'h26, 1, q);
        chk(q[0], e);
    endtask

    // n whole entries read from the first output byte, oldest first
    task automatic ent(input logic [7:0] k, input int n);
        host.rreg(7'h28, 5 * n, q);
        chk(8'(q.size()), 8'(5 * n));
        for (int j = 0; j < 5 * n; j++) chk(q[j], sb(k + 8'(j / 5), j % 5));
    endtask

    task automatic trig;
        @(posedge CLK);
        TRIGGER <= 1'b1;
        @(posedge CLK);
        TRIGGER <= 1'b0;
    endtask

    // disabling the buffer empties it; mode writes also forget a trigger
    task automatic clr(input logic [7:0] cfg);
        host.wreg(7'h11, 8'h10);
        host.wreg(7'h11, 8'h50);
        host.wreg(7'h14, cfg);
    endtask

    initial begin
        RST_N = 1'b0;
        SAMPLE_VALID = 1'b0;
        SAMPLE_DATA = '0;
        TRIGGER = 1'b0;
        kk = 8'h00;
        repeat (16) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge CLK);
        foreach (ra[i]) begin
            host.rreg(ra[i], 1, q);
            chk(q[0], rv[i]);
        end
        $display("test reset values done");
        host.wreg(7'h11, 8'h50);
        push(3);
        st(8'h00);
        host.wreg(7'h26, 8'hff);
        st(8'h00);
        $display("test bypass done");
        host.wreg(7'h11, 8'h70);
        host.wreg(7'h14, 8'h24);
        b = kk;
        push(3);
        st(8'h03);
        // watermark routed to the pin: quiet below the level, up once reached
        host.wreg(7'h12, 8'h01);
        repeat (2) @(posedge CLK);
        chk({7'h00, SAMPLE_READY_IRQ_PIN}, 8'h00);
        push(1);
        st(8'h84);
        chk({7'h00, SAMPLE_READY_IRQ_PIN}, 8'h01);
        push(28);
        st(8'ha0);
        // only the full source routed now; the pin must still be up
        host.wreg(7'h12, 8'h04);
        repeat (2) @(posedge CLK);
        chk({7'h00, SAMPLE_READY_IRQ_PIN}, 8'h01);
        push(1);
        st(8'he0);
        st(8'ha0);
        ent(b, 32);
        st(8'h00);
        chk({7'h00, SAMPLE_READY_IRQ_PIN}, 8'h00);
        host.wreg(7'h12, 8'h00);
        $display("test fill and stop done");
        host.wreg(7'h11, 8'h50);
        host.wreg(7'h14, 8'h40);
        b = kk;
        push(34);
        st(8'h60);
        ent(b + 8'h02, 1);
        $display("test stream done");
        clr(8'h60);
        b = kk;
        push(34);
        trig();
        push(1);
        ent(b + 8'h02, 1);
        st(8'h5f);
        $display("test stream then stop done");
        clr(8'h80);
        push(2);
        st(8'h00);
        trig();
        b = kk;
        push(2);
        st(8'h02);
        ent(b, 1);
        $display("test bypass then stream done");
        clr(8'he0);
        push(2);
        st(8'h00);
        trig();
        b = kk;
        push(34);
        host.wreg(7'h12, 8'h02);
        repeat (3) @(posedge CLK);
        chk({7'h00, SAMPLE_READY_IRQ_PIN}, 8'h01);
        st(8'h60);
        ent(b, 1);
        repeat (3) @(posedge CLK);
        chk({7'h00, SAMPLE_READY_IRQ_PIN}, 8'h00);
        $display("test bypass then stop done");
        // an unused mode code keeps the buffer empty even after a trigger
        clr(8'ha0);
        trig();
        push(2);
        st(8'h00);
        $display("test unused mode done");
        host.wreg(7'h0b, 8'h5a);
        repeat (2) @(posedge CLK);
        chk(TRIG_CFG, 8'h5a);
        host.rreg(7'h0b, 2, q);
        chk(q[0], 8'h5a);
        chk(q[1], 8'h00);
        host.wreg(7'h11, 8'h00);
        host.rreg(7'h0b, 2, q);
        chk(q[0], 8'h5a);
        chk(q[1], 8'h5a);
        $display("test sub-address done");
        wrap_up();
    end
endmodule

// [test/sfm_host.sv]
`timescale 1ns/1ps

// host on the register port: strobes change just after an edge
module sfm_host (
    input wire logic clk,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    output sfm_pkg::sfm_req_t req
);
    initial req = '0;

    // load the sub-address, then one write strobe at that address
    task automatic wreg(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{1'b1, a, 1'b0, 1'b0, 8'h00};
        @(posedge clk);
        req <= '{1'b0, a, 1'b1, 1'b0, d};
        @(posedge clk);
        req <= '0;
    endtask

    // back-to-back reads; each byte is taken at the edge where rvalid is seen
    task automatic rreg(input logic [6:0] a, input int n, ref logic [7:0] q[$]);
        q = {};
        @(posedge clk);
        req <= '{1'b1, a, 1'b0, 1'b0, 8'h00};
        for (int i = 0; i <= n + 1; i++) begin
            @(posedge clk);
            if (rvalid) q.push_back(rdata);
            req <= '{1'b0, a, 1'b0, i < n, 8'h00};
        end
    endtask
endmodule

// [test/sfm_top_sva.sv]
`timescale 1ns/1ps

// a shadow sub-address tells the trigger, unmapped and status checks which register a strobe hits
module sfm_top_sva #(
    parameter int DEPTH = sfm_pkg::FIFO_DEPTH
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire sfm_pkg::sfm_req_t REG_REQ,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic [7:0] TRIG_CFG,
    input wire logic SAMPLE_READY_IRQ_PIN
);
    logic [6:0] cur_r;
    logic [7:0] ct2_r;
    logic [7:0] ct3_r;
    logic [7:0] cfg_r;
    logic [7:0] trig_r;
    logic st_rd;
    logic wr_trig;

    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    assign st_rd = REG_REQ.rd && cur_r == sfm_pkg::ADDR_BUF_STATE;
    assign wr_trig = REG_REQ.wr && cur_r == sfm_pkg::ADDR_TRIG_CFG;

    // shadow registers; an access uses the address held before the edge
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cur_r <= 7'h00;
            ct2_r <= sfm_pkg::CTRL_TWO_RST;
            ct3_r <= 8'h00;
            cfg_r <= 8'h00;
            trig_r <= 8'h00;
        end else begin
            if (REG_REQ.wr && cur_r == 7'h11) ct2_r <= REG_REQ.wdata;
            if (REG_REQ.wr && cur_r == 7'h12) ct3_r <= REG_REQ.wdata;
            if (REG_REQ.wr && cur_r == 7'h14) cfg_r <= REG_REQ.wdata;
            if (wr_trig) trig_r <= REG_REQ.wdata;
            if (REG_REQ.addr_load) cur_r <= REG_REQ.addr;
            else if ((REG_REQ.rd || REG_REQ.wr) && ct2_r[4])
                cur_r <= (ct2_r[6] && cur_r == 7'h2c) ? 7'h28 : cur_r + 7'h01;
        end
    end

    rd_answer_a: assert property (REG_REQ.rd |=> REG_RVALID)
        else $error("read strobe not answered");
    no_stray_a: assert property (!REG_REQ.rd |=> !REG_RVALID)
        else $error("answer without a read");
    rdata_hold_a: assert property (!REG_RVALID |-> $stable(REG_RDATA))
        else $error("read byte moved without an answer");
    trig_copy_a: assert property (wr_trig |-> ##2 TRIG_CFG == trig_r)
        else $error("trigger setup copy wrong");
    trig_keep_a: assert property (!REG_REQ.wr [*2] |=> $stable(TRIG_CFG))
        else $error("trigger setup moved without a write");
    unmapped_zero_a: assert property (REG_REQ.rd && cur_r == 7'h0c |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    level_cap_a: assert property (st_rd |=> REG_RDATA[5:0] <= DEPTH)
        else $error("level above depth");
    bypass_empty_a: assert property (st_rd && cfg_r < 8'h20 && $past(cfg_r) < 8'h20
        |=> REG_RDATA[5:0] == 6'h00) else $error("bypass buffer not empty");
    wtm_flag_a: assert property (st_rd |=> REG_RDATA[7] ==
        ($past(ct2_r[5]) && REG_RDATA[4:0] >= $past(cfg_r[4:0]) || $past(ct2_r[5]) && REG_RDATA[5]))
        else $error("watermark flag wrong");
    pin_quiet_a: assert property ((ct3_r == 8'h00) [*3] |-> !SAMPLE_READY_IRQ_PIN)
        else $error("pin raised with no source routed");
endmodule

bind sfm_top sfm_top_sva #(.DEPTH(DEPTH)) u_sva (
    .CLK(CLK), .RST_N(RST_N), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .TRIG_CFG(TRIG_CFG),
    .SAMPLE_READY_IRQ_PIN(SAMPLE_READY_IRQ_PIN)
);
